// ---- mmsp_pkg.sv ----
package mmsp_pkg;
    // Clock and reset-pulse timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int RESET_INIT_NS = 10000;
    localparam int RESET_INIT_CYC = (RESET_INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RST_CNT_W = 12;
    localparam logic [RST_CNT_W-1:0] RESET_INIT_M1 = RST_CNT_W'(RESET_INIT_CYC - 1);

    // Host-addressable space
    localparam int MEM_BYTES = 256;
    localparam int PAGE_BYTES = 128;
    localparam logic [7:0] LOWER_BASE = 8'h00;
    localparam logic [7:0] UPPER_BASE = 8'h80;

    // Lower-memory control and status bytes
    localparam logic [7:0] FLAG_OFF = 8'h03;
    localparam logic [7:0] LPCTL_OFF = 8'h1a;
    localparam logic [7:0] BANK_SEL_OFF = 8'h7e;
    localparam logic [7:0] PAGE_SEL_OFF = 8'h7f;
    localparam int LP_FORCE_BIT = 0;

    // Implemented pages
    localparam logic [7:0] PAGE_00 = 8'h00;
    localparam logic [7:0] PAGE_01 = 8'h01;
    localparam logic [7:0] PAGE_02 = 8'h02;
    localparam logic [7:0] PAGE_10 = 8'h10;
    localparam logic [7:0] PAGE_11 = 8'h11;
    localparam int FIXED_PAGES = 3;
    localparam int BANKED_PAGES = 2;

    // Values after reset
    localparam logic [7:0] PAGE_SEL_RST = 8'h00;
    localparam logic [7:0] BANK_SEL_RST = 8'h00;
    localparam logic LP_FORCE_RST = 1'b0;
    localparam logic [4:0] PIN_SYNC_RST = 5'h1f;

    // Two-wire framing
    localparam logic [6:0] DEV_ADDR_DFLT = 7'h50;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_ACK_A = 3'b010,
        ST_WDATA = 3'b011,
        ST_ACK_W = 3'b100,
        ST_RDATA = 3'b101,
        ST_ACK_R = 3'b110
    } mmsp_state_t;
endpackage

// ---- mmsp_top.sv ----
`timescale 1ns/1ps
module mmsp_top #(
    parameter logic [6:0] DEV_ADDR = mmsp_pkg::DEV_ADDR_DFLT,
    parameter int NBANK = 1
) (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic module_select_n_i,
    input wire logic module_reset_n_i,
    input wire logic low_power_request_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic [7:0] flag_event_i,
    output logic sda_o,
    output logic sda_oe_o,
    output logic module_present_n_o,
    output logic interrupt_out_n_o,
    output logic interrupt_out_n_oe_o,
    output logic low_power_mode_o,
    output logic user_reset_o
);
    import mmsp_pkg::*;

    localparam int SLOTS = FIXED_PAGES + BANKED_PAGES * NBANK;

    if (NBANK < 1 || NBANK > 4) begin : g_chk
        $error("NBANK must be 1 to 4");
    end

    logic [4:0] pin_s1_r;
    logic [4:0] pin_s2_r;
    logic scl_d_r;
    logic sda_d_r;
    logic sel_n_s;
    logic rst_n_s;
    logic lp_s;
    logic scl_s;
    logic sda_s;
    logic start_det;
    logic stop_det;
    logic scl_rise;
    logic scl_fall;
    logic [RST_CNT_W-1:0] rst_cnt_r;
    logic user_rst_r;
    mmsp_state_t st_r;
    logic [3:0] cnt_r;
    logic [7:0] sh_r;
    logic [7:0] tx_r;
    logic rw_r;
    logic first_r;
    logic mack_r;
    logic [7:0] ptr_r;
    logic sda_oe_r;
    logic wr_en_r;
    logic [7:0] wr_addr_r;
    logic [7:0] wr_data_r;
    logic [7:0] act_page_r;
    logic [7:0] act_bank_r;
    logic [7:0] page_sel_r;
    logic [7:0] bank_sel_r;
    logic lp_force_r;
    logic lp_mode_r;
    logic [7:0] flags_r;
    logic [7:0] flags_nxt;
    logic [7:0] flag_clr_r;
    logic int_oe_r;
    logic [7:0] ld_byte;
    logic do_load;
    logic [7:0] lower_mem [0:PAGE_BYTES-1];
    logic [7:0] page_mem [0:SLOTS*PAGE_BYTES-1];

    // Maps page and bank to a storage slot, -1 when not implemented
    function automatic int slot_idx(input logic [7:0] pg, input logic [7:0] bk);
        int s;
        s = -1;
        case (pg)
            PAGE_00: s = 0;
            PAGE_01: s = 1;
            PAGE_02: s = 2;
            PAGE_10: s = FIXED_PAGES + BANKED_PAGES * int'(bk);
            PAGE_11: s = FIXED_PAGES + BANKED_PAGES * int'(bk) + 1;
            default: s = -1;
        endcase
        if ((pg == PAGE_10 || pg == PAGE_11) && int'(bk) >= NBANK) begin
            s = -1;
        end
        return s;
    endfunction

    // Byte seen by the host at offset a
    function automatic logic [7:0] rd_byte(input logic [7:0] a);
        int s;
        logic [7:0] d;
        s = slot_idx(act_page_r, act_bank_r);
        d = 8'h00;
        if (a < UPPER_BASE) begin
            case (a)
                FLAG_OFF: d = flags_r;
                PAGE_SEL_OFF: d = page_sel_r;
                BANK_SEL_OFF: d = bank_sel_r;
                LPCTL_OFF: d = {7'h00, lp_force_r};
                default: d = lower_mem[a[6:0]];
            endcase
        end else if (s >= 0) begin
            d = page_mem[s * PAGE_BYTES + int'(a[6:0])];
        end
        return d;
    endfunction

    // Undriven pins read high: flops preset to one
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pin_s1_r <= PIN_SYNC_RST;
            pin_s2_r <= PIN_SYNC_RST;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            pin_s1_r <= {module_select_n_i, module_reset_n_i, low_power_request_i, scl_i, sda_i};
            pin_s2_r <= pin_s1_r;
            scl_d_r <= pin_s2_r[1];
            sda_d_r <= pin_s2_r[0];
        end
    end

    assign sel_n_s = pin_s2_r[4];
    assign rst_n_s = pin_s2_r[3];
    assign lp_s = pin_s2_r[2];
    assign scl_s = pin_s2_r[1];
    assign sda_s = pin_s2_r[0];
    assign start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
    assign stop_det = scl_s & scl_d_r & ~sda_d_r & sda_s;
    assign scl_rise = scl_s & ~scl_d_r;
    assign scl_fall = ~scl_s & scl_d_r;

    // Reset pin must stay low past the minimum pulse before acting
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_cnt_r <= '0;
            user_rst_r <= 1'b0;
        end else begin
            if (rst_n_s) begin
                rst_cnt_r <= '0;
            end else if (rst_cnt_r != RESET_INIT_M1) begin
                rst_cnt_r <= rst_cnt_r + RST_CNT_W'(1);
            end
            user_rst_r <= ~rst_n_s && (rst_cnt_r == RESET_INIT_M1);
        end
    end

    always_comb ld_byte = rd_byte(ptr_r);
    assign do_load = (st_r == ST_ACK_A && rw_r) || (st_r == ST_ACK_R && mack_r);

    // Two-wire slave; data changes only after a falling clock edge
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_r <= ST_IDLE;
            cnt_r <= 4'h0;
            sh_r <= 8'h00;
            tx_r <= 8'h00;
            rw_r <= 1'b0;
            first_r <= 1'b0;
            mack_r <= 1'b0;
            ptr_r <= 8'h00;
            sda_oe_r <= 1'b0;
            wr_en_r <= 1'b0;
            wr_addr_r <= 8'h00;
            wr_data_r <= 8'h00;
            flag_clr_r <= 8'h00;
            act_page_r <= PAGE_SEL_RST;
            act_bank_r <= BANK_SEL_RST;
        end else begin
            wr_en_r <= 1'b0;
            flag_clr_r <= 8'h00;
            if (sel_n_s || stop_det || user_rst_r) begin
                st_r <= ST_IDLE;
                sda_oe_r <= 1'b0;
            end else if (start_det) begin
                st_r <= ST_ADDR;
                cnt_r <= 4'h0;
                sda_oe_r <= 1'b0;
                act_page_r <= page_sel_r;
                act_bank_r <= bank_sel_r;
            end else if (scl_rise) begin
                case (st_r)
                    ST_ADDR, ST_WDATA: begin
                        sh_r <= {sh_r[6:0], sda_s};
                        cnt_r <= cnt_r + 4'h1;
                    end
                    ST_RDATA: cnt_r <= cnt_r + 4'h1;
                    ST_ACK_R: mack_r <= ~sda_s;
                    default: cnt_r <= cnt_r;
                endcase
            end else if (scl_fall) begin
                if (do_load) begin
                    tx_r <= ld_byte;
                    sda_oe_r <= ~ld_byte[7];
                    ptr_r <= ptr_r + 8'h01;
                    cnt_r <= 4'h0;
                    st_r <= ST_RDATA;
                    if (ptr_r == FLAG_OFF) begin
                        flag_clr_r <= ld_byte;
                    end
                end else begin
                    case (st_r)
                        ST_ADDR: begin
                            if (cnt_r == BITS_PER_BYTE) begin
                                cnt_r <= 4'h0;
                                if (sh_r[7:1] == DEV_ADDR) begin
                                    sda_oe_r <= 1'b1;
                                    rw_r <= sh_r[0];
                                    first_r <= ~sh_r[0];
                                    st_r <= ST_ACK_A;
                                end else begin
                                    st_r <= ST_IDLE;
                                end
                            end
                        end
                        ST_WDATA: begin
                            if (cnt_r == BITS_PER_BYTE) begin
                                cnt_r <= 4'h0;
                                sda_oe_r <= 1'b1;
                                st_r <= ST_ACK_W;
                                if (first_r) begin
                                    ptr_r <= sh_r;
                                    first_r <= 1'b0;
                                end else begin
                                    wr_en_r <= 1'b1;
                                    wr_addr_r <= ptr_r;
                                    wr_data_r <= sh_r;
                                    ptr_r <= ptr_r + 8'h01;
                                end
                            end
                        end
                        ST_ACK_A, ST_ACK_W: begin
                            sda_oe_r <= 1'b0;
                            st_r <= ST_WDATA;
                        end
                        ST_RDATA: begin
                            if (cnt_r == BITS_PER_BYTE) begin
                                sda_oe_r <= 1'b0;
                                cnt_r <= 4'h0;
                                st_r <= ST_ACK_R;
                            end else begin
                                sda_oe_r <= ~tx_r[6];
                                tx_r <= {tx_r[6:0], 1'b0};
                            end
                        end
                        ST_ACK_R: st_r <= ST_IDLE;
                        default: st_r <= ST_IDLE;
                    endcase
                end
            end
        end
    end

    // User settings; long reset pulse restores defaults
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            page_sel_r <= PAGE_SEL_RST;
            bank_sel_r <= BANK_SEL_RST;
            lp_force_r <= LP_FORCE_RST;
        end else if (user_rst_r) begin
            page_sel_r <= PAGE_SEL_RST;
            bank_sel_r <= BANK_SEL_RST;
            lp_force_r <= LP_FORCE_RST;
        end else if (wr_en_r) begin
            if (wr_addr_r == PAGE_SEL_OFF) begin
                page_sel_r <= wr_data_r;
            end
            if (wr_addr_r == BANK_SEL_OFF) begin
                bank_sel_r <= wr_data_r;
            end
            if (wr_addr_r == LPCTL_OFF) begin
                lp_force_r <= wr_data_r[LP_FORCE_BIT];
            end
        end
    end

    // Storage is left unreset; contents are not user settings
    always_ff @(posedge ref_clk_i) begin
        if (wr_en_r) begin
            if (wr_addr_r < UPPER_BASE) begin
                lower_mem[wr_addr_r[6:0]] <= wr_data_r;
            end else if (slot_idx(act_page_r, act_bank_r) >= 0) begin
                page_mem[slot_idx(act_page_r, act_bank_r) * PAGE_BYTES
                    + int'(wr_addr_r[6:0])] <= wr_data_r;
            end
        end
    end

    // A new event wins over a clear in the same cycle
    assign flags_nxt = (flags_r & ~flag_clr_r) | flag_event_i;

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            flags_r <= 8'h00;
            int_oe_r <= 1'b0;
        end else if (user_rst_r) begin
            flags_r <= 8'h00;
            int_oe_r <= 1'b0;
        end else begin
            flags_r <= flags_nxt;
            int_oe_r <= |flags_nxt;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            lp_mode_r <= 1'b1;
        end else begin
            lp_mode_r <= lp_s | lp_force_r;
        end
    end

    assign sda_o = 1'b0;
    assign sda_oe_o = sda_oe_r;
    assign module_present_n_o = 1'b0;
    assign interrupt_out_n_o = 1'b0;
    assign interrupt_out_n_oe_o = int_oe_r;
    assign low_power_mode_o = lp_mode_r;
    assign user_reset_o = user_rst_r;

    a_desel_quiet: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        sel_n_s |=> !sda_oe_o && st_r == ST_IDLE) else $error("deselected module drives bus");
    a_sel_ack: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        $rose(sda_oe_o) |-> !$past(sel_n_s)) else $error("bus driven while not selected");
    a_rst_short: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        rst_n_s |=> !user_rst_r ##1 !user_rst_r) else $error("reset acted on short pulse");
    a_rst_dflt: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        user_rst_r |=> page_sel_r == PAGE_SEL_RST && bank_sel_r == BANK_SEL_RST && !lp_force_r)
        else $error("settings not restored");
    a_lp_mode: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        lp_s |=> low_power_mode_o) else $error("low-power request ignored");
    a_present_low: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        module_present_n_o == 1'b0) else $error("presence not low");
    a_int_set: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i || user_rst_r)
        flag_event_i != 8'h00 |=> interrupt_out_n_oe_o && flags_r != 8'h00)
        else $error("event did not assert interrupt");
    a_int_release: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        $fell(interrupt_out_n_oe_o) |-> $past(flag_clr_r) != 8'h00 || $past(user_rst_r))
        else $error("interrupt released without flag read");
    a_page_latch: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        start_det && !sel_n_s && !stop_det && !user_rst_r |=> act_page_r == $past(page_sel_r)
        ##1 act_page_r == $past(act_page_r)) else $error("page not latched at start");
    a_unmapped_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        ptr_r[7] && slot_idx(act_page_r, act_bank_r) < 0 |-> ld_byte == 8'h00)
        else $error("unimplemented page reads nonzero");

    c_addr_ack: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        st_r == ST_ACK_A && rw_r);
    c_flag_read: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        flag_clr_r != 8'h00);
    c_user_rst: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i) user_rst_r);
    c_page_sw: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        start_det ##1 act_page_r == PAGE_11);
endmodule

// ---- mmsp_host_model.sv ----
`timescale 1ns/1ps
module mmsp_host_model (
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_oe_o,
    output logic select_n_o
);
    // Half of the 48 ns link clock; it stands high between frames
    localparam int HALF_NS = 24;

    initial begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
        select_n_o = 1'b1;
    end

    // Several idle link periods after any select change, before traffic
    task automatic sel(input logic v);
        select_n_o = v;
        #(8 * HALF_NS);
    endtask

    // Data moves an eighth of a period after the fall, so no edge races the sync
    task automatic bit_io(input logic b, output logic s);
        #(HALF_NS / 4) sda_oe_o = ~b;
        #(HALF_NS * 3 / 4) scl_o = 1'b1;
        #HALF_NS s = sda_i;
        scl_o = 1'b0;
    endtask

    task automatic start();
        #(HALF_NS / 4) sda_oe_o = 1'b0;
        #(HALF_NS * 3 / 4) scl_o = 1'b1;
        #HALF_NS sda_oe_o = 1'b1;
        #HALF_NS scl_o = 1'b0;
    endtask

    task automatic stop();
        #(HALF_NS / 4) sda_oe_o = 1'b1;
        #(HALF_NS * 3 / 4) scl_o = 1'b1;
        #HALF_NS sda_oe_o = 1'b0;
        #HALF_NS;
    endtask

    // Eight bits MSB first, then the acknowledge slot
    task automatic xfer(input logic [7:0] b, input logic ack_in, output logic [7:0] r,
                        output logic ack_out);
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], r[i]);
        end
        bit_io(ack_in, ack_out);
    endtask
endmodule

// ---- tb_module_mgmt_select_paging.sv ----
`timescale 1ns/1ps
module tb_module_mgmt_select_paging;
    import mmsp_pkg::*;
    localparam int NB = 2;
    logic ref_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic mod_rst_n = 1'b1;
    logic lp_req = 1'b0;
    logic [7:0] flag_ev = 8'h00;
    logic scl, sel_n, host_oe, sda_o, sda_oe, prs_n, int_n, int_oe, lp_mode, usr_rst;
    wire logic sda_w = ~(host_oe | (sda_oe & ~sda_o));
    int bad_count = 0;
    int num_checks = 0;
    int seed = 32'h9695;
    int mem[int];
    int flags = 0, m_page = 0, m_bank = 0, a_page = 0, a_bank = 0;

    mmsp_top #(.DEV_ADDR(DEV_ADDR_DFLT), .NBANK(NB)) u_mmsp_top (
        .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .module_select_n_i(sel_n),
        .module_reset_n_i(mod_rst_n), .low_power_request_i(lp_req), .scl_i(scl),
        .sda_i(sda_w), .flag_event_i(flag_ev), .sda_o(sda_o), .sda_oe_o(sda_oe),
        .module_present_n_o(prs_n), .interrupt_out_n_o(int_n),
        .interrupt_out_n_oe_o(int_oe), .low_power_mode_o(lp_mode), .user_reset_o(usr_rst));
    mmsp_host_model u_mmsp_host_model (
        .sda_i(sda_w), .scl_o(scl), .sda_oe_o(host_oe), .select_n_o(sel_n));

    initial begin
        forever #2 ref_clk_i = ~ref_clk_i;
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk8(string w, logic [7:0] e, logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", w, e, g);
        end
    endtask

    task automatic chk1(string w, logic e, logic g);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %b seen %b", w, e, g);
        end
    endtask

    task automatic step(int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask

    // Unimplemented upper pages give -1: writes dropped, reads zero
    function automatic int key(int off);
        if (off < 128) return off;
        if (a_page <= 2) return (a_page << 16) | off;
        if ((a_page == 'h10 || a_page == 'h11) && a_bank < NB) begin
            return (a_page << 16) | (a_bank << 8) | off;
        end
        return -1;
    endfunction

    function automatic int expv(int off);
        int k;
        k = key(off);
        if (off == 'h7f) return m_page;
        if (off == 'h7e) return m_bank;
        if (k < 0) return 0;
        return mem.exists(k) ? mem[k] : -1;
    endfunction

    task automatic snd(logic [7:0] b);
        logic [7:0] r;
        logic a;
        u_mmsp_host_model.xfer(b, 1'b1, r, a);
        chk1("ack", 1'b0, a);
    endtask

    // Page and bank selections become active at a START
    task automatic open_at(int off);
        u_mmsp_host_model.start();
        a_page = m_page;
        a_bank = m_bank;
        snd({DEV_ADDR_DFLT, 1'b0});
        snd(8'(off));
    endtask

    task automatic wr(int off, logic [7:0] dq[$]);
        open_at(off);
        foreach (dq[i]) begin
            snd(dq[i]);
            if (off == 'h7f) m_page = dq[i];
            else if (off == 'h7e) m_bank = dq[i];
            else if (key(off) >= 0) mem[key(off)] = dq[i];
            off = (off + 1) % 256;
        end
        u_mmsp_host_model.stop();
    endtask

    task automatic rd(int off, int n);
        logic [7:0] r;
        logic a;
        int e;
        open_at(off);
        u_mmsp_host_model.start();
        snd({DEV_ADDR_DFLT, 1'b1});
        for (int i = 0; i < n; i++) begin
            u_mmsp_host_model.xfer(8'hff, i == n - 1, r, a);
            e = (off == 3) ? flags : expv(off);
            if (off == 3) flags = 0;
            if (e >= 0) chk8("read byte", 8'(e), r);
            off = (off + 1) % 256;
        end
        u_mmsp_host_model.stop();
    endtask

    initial begin
        #300000;
        bad_count++;
        $display("mismatch watchdog expected done seen hang");
        complete_run();
    end

    initial begin
        logic [7:0] d;
        logic a;
        int n;
        int pl[6];
        pl = '{'h00, 'h01, 'h02, 'h10, 'h11, 'h12};
        step(20);
        chk1("lp mode in reset", 1'b1, lp_mode);
        rst_b_i = 1'b1;
        step(8);
        chk1("present", 1'b0, prs_n);
        chk1("int pin level", 1'b0, int_n);
        chk1("int idle", 1'b0, int_oe);
        lp_req = 1'b1;
        step(4);
        chk1("lp follows pin", 1'b1, lp_mode);
        lp_req = 1'b0;
        step(4);
        chk1("lp follows pin", 1'b0, lp_mode);
        $display("test pins done");
        u_mmsp_host_model.start();
        u_mmsp_host_model.xfer({DEV_ADDR_DFLT, 1'b0}, 1'b1, d, a);
        chk1("deselected ack", 1'b1, a);
        u_mmsp_host_model.stop();
        u_mmsp_host_model.sel(1'b0);
        wr('h40, '{8'($random(seed))});
        u_mmsp_host_model.start();
        u_mmsp_host_model.xfer({DEV_ADDR_DFLT ^ 7'h01, 1'b0}, 1'b1, d, a);
        chk1("wrong address ack", 1'b1, a);
        u_mmsp_host_model.stop();
        $display("test select done");
        foreach (pl[i]) begin
            for (int b = 0; b < 2; b++) begin
                wr('h7e, '{8'(b), 8'(pl[i])});
                wr('h90, '{8'($random(seed)), 8'($random(seed))});
            end
        end
        foreach (pl[i]) begin
            for (int b = 0; b < 2; b++) begin
                wr('h7e, '{8'(b), 8'(pl[i])});
                rd('h7e, 2);
                rd('h40, 1);
                rd('h90, 2);
            end
        end
        $display("test paging done");
        wr('h7f, '{8'h02});
        wr('h7f, '{8'h01, 8'($random(seed))});
        rd('h7f, 2);
        wr('h7f, '{8'h02});
        rd('h80, 1);
        $display("test select timing done");
        step(1);
        repeat (3) begin
            d = 8'($random(seed)) | 8'h01;
            flag_ev = d;
            flags = flags | d;
            step(1);
            flag_ev = 8'h00;
            for (int i = 0; i < 4 && int_oe !== 1'b1; i++) step(1);
            chk1("int asserted", 1'b1, int_oe);
            if (int_oe !== 1'b1) complete_run();
        end
        rd(3, 1);
        step(4);
        chk1("int released", 1'b0, int_oe);
        $display("test interrupt done");
        wr('h1a, '{8'h01});
        step(4);
        chk1("forced low power", 1'b1, lp_mode);
        mod_rst_n = 1'b0;
        step(100);
        mod_rst_n = 1'b1;
        step(4);
        chk1("short reset pulse", 1'b0, usr_rst);
        mod_rst_n = 1'b0;
        for (n = 0; n < 3000 && usr_rst !== 1'b1; n++) step(1);
        chk1("user reset", 1'b1, usr_rst);
        if (usr_rst !== 1'b1) complete_run();
        chk1("reset length", 1'b1, n >= RESET_INIT_CYC - 2 && n <= RESET_INIT_CYC + 4);
        mod_rst_n = 1'b1;
        m_page = 0;
        m_bank = 0;
        flags = 0;
        step(8);
        chk1("force cleared", 1'b0, lp_mode);
        rd('h7e, 2);
        $display("test module reset done");
        complete_run();
    end
endmodule
